// File: logic/exc_ref_pkg.sv
package exc_ref_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register map
	localparam logic [7:0] PIN_SELECT_ADDR = 8'h0d;
	localparam logic [7:0] LEVEL_ADDR = 8'h0e;
	localparam logic [7:0] REF_SELECT_ADDR = 8'h0f;
	localparam logic [7:0] STATUS_ADDR = 8'h20;

	// reset values
	localparam logic [7:0] PIN_SELECT_RESET = 8'hbb;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [7:0] REF_SELECT_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// field layout
	localparam int unsigned NIBBLE_W = 4;
	localparam int unsigned FIRST_NIBBLE_LSB = 0;
	localparam int unsigned SECOND_NIBBLE_LSB = 4;
	localparam int unsigned REF_FIELD_W = 3;
	localparam int unsigned NEG_REF_LSB = 0;
	localparam int unsigned POS_REF_LSB = 3;
	localparam logic [7:0] REF_WRITABLE_MASK = 8'h3f;

	// pin select codes: 0..9 analog inputs, then common input
	localparam int unsigned PIN_TARGETS = 11;
	localparam logic [3:0] PIN_CODE_COMMON = 4'ha;
	localparam logic [3:0] PIN_CODE_NONE = 4'hb;

	// level codes: 0 off, up to 4'ha
	localparam int unsigned LEVEL_STEPS = 11;
	localparam logic [3:0] LEVEL_CODE_OFF = 4'h0;
	localparam logic [3:0] LEVEL_CODE_MAX = 4'ha;
	localparam int unsigned CURRENT_W = 12;
	localparam logic [11:0] LEVEL_UA [0:10] = '{
		12'h000, 12'h032, 12'h064, 12'h0fa, 12'h1f4, 12'h2ee,
		12'h3e8, 12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8
	};

	// reference codes: internal, three pins, supply
	localparam int unsigned REF_CHOICES = 5;
	localparam logic [2:0] REF_CODE_INTERNAL = 3'h0;
	localparam logic [2:0] REF_CODE_SUPPLY = 3'h4;

	// status bits
	localparam int unsigned ST_FIRST_PIN_RSVD = 0;
	localparam int unsigned ST_SECOND_PIN_RSVD = 1;
	localparam int unsigned ST_FIRST_LEVEL_RSVD = 2;
	localparam int unsigned ST_SECOND_LEVEL_RSVD = 3;
	localparam int unsigned ST_POS_REF_RSVD = 4;
	localparam int unsigned ST_NEG_REF_RSVD = 5;
	localparam int unsigned ST_FIRST_DRIVING = 6;
	localparam int unsigned ST_SECOND_DRIVING = 7;

endpackage

// File: logic/code_decoder.sv
`timescale 1ns/1ps
module code_decoder
	import exc_ref_pkg::*;
#(
	parameter int unsigned CODE_W = 4,
	parameter int unsigned OUT_N = 11
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [CODE_W-1:0] code,
	output logic [OUT_N-1:0] sel,
	output logic valid
);

	logic [OUT_N-1:0] sel_next;
	logic valid_next;

	// codes at or above OUT_N select nothing
	genvar i;
	generate
		for (i = 0; i < OUT_N; i++)
		begin : g_hit
			assign sel_next[i] = (code == CODE_W'(i));
		end
	endgenerate

	assign valid_next = |sel_next;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			sel <= '0;
			valid <= 1'b0;
		end
		else if (ce)
		begin
			sel <= sel_next;
			valid <= valid_next;
		end
	end

endmodule

// File: logic/excitation_and_reference_select_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module excitation_and_reference_select_regs
	import exc_ref_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic [PIN_TARGETS-1:0] first_source_pin_sel,
	output logic [PIN_TARGETS-1:0] second_source_pin_sel,
	output logic [LEVEL_STEPS-1:0] first_source_level_sel,
	output logic [LEVEL_STEPS-1:0] second_source_level_sel,
	output logic [CURRENT_W-1:0] first_source_current_ua,
	output logic [CURRENT_W-1:0] second_source_current_ua,
	output logic [REF_CHOICES-1:0] positive_reference_sel,
	output logic [REF_CHOICES-1:0] negative_reference_sel
);

	logic [DATA_W-1:0] pin_select_reg;
	logic [DATA_W-1:0] pin_select_next;
	logic [DATA_W-1:0] level_reg;
	logic [DATA_W-1:0] level_next;
	logic [DATA_W-1:0] ref_select_reg;
	logic [DATA_W-1:0] ref_select_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] status_word;

	wire hit_pin = (reg_addr == PIN_SELECT_ADDR);
	wire hit_level = (reg_addr == LEVEL_ADDR);
	wire hit_ref = (reg_addr == REF_SELECT_ADDR);
	wire hit_status = (reg_addr == STATUS_ADDR);

	assign pin_select_next = (reg_wr && hit_pin) ? reg_wdata : pin_select_reg;
	// level write, both nibbles stored as written
	assign level_next = (reg_wr && hit_level) ? reg_wdata : level_reg;
	// reserved reference bits dropped on write
	assign ref_select_next = (reg_wr && hit_ref) ?
		(reg_wdata & REF_WRITABLE_MASK) : ref_select_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_select_reg <= PIN_SELECT_RESET;
			level_reg <= LEVEL_RESET;
			ref_select_reg <= REF_SELECT_RESET;
		end
		else if (ce)
		begin
			pin_select_reg <= pin_select_next;
			level_reg <= level_next;
			ref_select_reg <= ref_select_next;
		end
	end

	// per-source fields, index 0 first source, 1 second source
	logic [NIBBLE_W-1:0] pin_field [0:1];
	logic [NIBBLE_W-1:0] level_field [0:1];
	logic [PIN_TARGETS-1:0] pin_sel [0:1];
	logic [LEVEL_STEPS-1:0] level_sel [0:1];
	logic [1:0] pin_connected;
	logic [1:0] level_valid;
	logic [1:0] pin_reserved;
	logic [1:0] level_reserved;
	logic [CURRENT_W-1:0] current_reg [0:1];
	logic [CURRENT_W-1:0] current_next [0:1];

	assign pin_field[0] =
		pin_select_reg[FIRST_NIBBLE_LSB +: NIBBLE_W];
	assign pin_field[1] =
		pin_select_reg[SECOND_NIBBLE_LSB +: NIBBLE_W];
	// first source level in low nibble
	assign level_field[0] = level_reg[FIRST_NIBBLE_LSB +: NIBBLE_W];
	// second source level in high nibble
	assign level_field[1] = level_reg[SECOND_NIBBLE_LSB +: NIBBLE_W];

	genvar s;
	generate
		for (s = 0; s < 2; s++)
		begin : g_source
			// codes past common input select no pin
			code_decoder #(
				.CODE_W(NIBBLE_W),
				.OUT_N(PIN_TARGETS)
			) u_pin (
				.clock(clock),
				.rstn(rstn),
				.ce(ce),
				.code(pin_field[s]),
				.sel(pin_sel[s]),
				.valid(pin_connected[s])
			);
			// reserved level codes give no step at all
			code_decoder #(
				.CODE_W(NIBBLE_W),
				.OUT_N(LEVEL_STEPS)
			) u_level (
				.clock(clock),
				.rstn(rstn),
				.ce(ce),
				.code(level_field[s]),
				.sel(level_sel[s]),
				.valid(level_valid[s])
			);
			// reserved pin codes flagged in status
			assign pin_reserved[s] = (pin_field[s] > PIN_CODE_NONE);
			assign level_reserved[s] = (level_field[s] > LEVEL_CODE_MAX);
			assign current_next[s] = level_reserved[s] ?
				LEVEL_UA[LEVEL_CODE_OFF] : LEVEL_UA[level_field[s]];
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
					current_reg[s] <= LEVEL_UA[LEVEL_CODE_OFF];
				else if (ce)
					current_reg[s] <= current_next[s];
			end
		end
	endgenerate

	assign first_source_pin_sel = pin_sel[0];
	assign second_source_pin_sel = pin_sel[1];
	assign first_source_level_sel = level_sel[0];
	assign second_source_level_sel = level_sel[1];
	assign first_source_current_ua = current_reg[0];
	assign second_source_current_ua = current_reg[1];

	logic [REF_FIELD_W-1:0] pos_field;
	logic [REF_FIELD_W-1:0] neg_field;
	logic pos_valid;
	logic neg_valid;

	assign pos_field = ref_select_reg[POS_REF_LSB +: REF_FIELD_W];
	assign neg_field = ref_select_reg[NEG_REF_LSB +: REF_FIELD_W];

	// reserved codes leave positive reference unselected
	code_decoder #(
		.CODE_W(REF_FIELD_W),
		.OUT_N(REF_CHOICES)
	) u_pos_ref (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.code(pos_field),
		.sel(positive_reference_sel),
		.valid(pos_valid)
	);

	// reserved codes leave negative reference unselected
	code_decoder #(
		.CODE_W(REF_FIELD_W),
		.OUT_N(REF_CHOICES)
	) u_neg_ref (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.code(neg_field),
		.sel(negative_reference_sel),
		.valid(neg_valid)
	);

	// a source drives only if routed to a pin and set above off
	wire first_driving = pin_connected[0] && level_valid[0] &&
		!level_sel[0][LEVEL_CODE_OFF];
	wire second_driving = pin_connected[1] && level_valid[1] &&
		!level_sel[1][LEVEL_CODE_OFF];

	always_comb
	begin
		status_word = READ_IDLE;
		status_word[ST_FIRST_PIN_RSVD] = pin_reserved[0];
		status_word[ST_SECOND_PIN_RSVD] = pin_reserved[1];
		status_word[ST_FIRST_LEVEL_RSVD] = level_reserved[0];
		status_word[ST_SECOND_LEVEL_RSVD] = level_reserved[1];
		status_word[ST_POS_REF_RSVD] = !pos_valid;
		status_word[ST_NEG_REF_RSVD] = !neg_valid;
		status_word[ST_FIRST_DRIVING] = first_driving;
		status_word[ST_SECOND_DRIVING] = second_driving;
	end

	// read data stand for one enabled cycle per read strobe, zero otherwise
	assign rdata_next = !reg_rd ? READ_IDLE :
		hit_pin ? pin_select_reg :
		hit_level ? level_reg :
		hit_ref ? ref_select_reg :
		hit_status ? status_word :
		READ_IDLE;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= READ_IDLE;
		else if (ce)
			rdata_reg <= rdata_next;
	end

	assign reg_rdata = rdata_reg;

endmodule

// File: sim/excitation_and_reference_select_regs_asserts.sv
`timescale 1ns/1ps
module exc_ref_checker
	import exc_ref_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [PIN_TARGETS-1:0] first_source_pin_sel,
	input wire logic [PIN_TARGETS-1:0] second_source_pin_sel,
	input wire logic [LEVEL_STEPS-1:0] first_source_level_sel,
	input wire logic [CURRENT_W-1:0] second_source_current_ua,
	input wire logic [REF_CHOICES-1:0] positive_reference_sel,
	input wire logic [REF_CHOICES-1:0] negative_reference_sel
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// decode lags the register by one enabled edge
	wire logic pin_wr = ce && reg_wr && reg_addr == PIN_SELECT_ADDR;
	wire logic lvl_wr = ce && reg_wr && reg_addr == LEVEL_ADDR;
	wire logic ref_wr = ce && reg_wr && reg_addr == REF_SELECT_ADDR;
	property p_pin2;
		pin_wr && reg_wdata[7:4] < 4'hb ##1 ce |=>
		second_source_pin_sel == 11'h001 << $past(reg_wdata[7:4], 2);
	endproperty
	a_pin2: assert property (p_pin2)
		else $error("second pin select wrong");
	property p_pin1;
		pin_wr && reg_wdata[3:0] < 4'hb ##1 ce |=>
		first_source_pin_sel == 11'h001 << $past(reg_wdata[3:0], 2);
	endproperty
	a_pin1: assert property (p_pin1)
		else $error("first pin select wrong");
	property p_pin_off;
		pin_wr && reg_wdata[3:0] > 4'ha ##1 ce |=> first_source_pin_sel == 11'h000;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("first source not disconnected");
	property p_cur2;
		lvl_wr && reg_wdata[7:4] < 4'hb ##1 ce |=>
		second_source_current_ua == LEVEL_UA[$past(reg_wdata[7:4], 2)];
	endproperty
	a_cur2: assert property (p_cur2)
		else $error("second current wrong");
	property p_lvl1;
		lvl_wr && reg_wdata[3:0] < 4'hb ##1 ce |=>
		first_source_level_sel == 11'h001 << $past(reg_wdata[3:0], 2);
	endproperty
	a_lvl1: assert property (p_lvl1)
		else $error("first level select wrong");
	property p_pos;
		ref_wr && reg_wdata[5:3] < 3'h5 ##1 ce |=>
		positive_reference_sel == 5'h01 << $past(reg_wdata[5:3], 2);
	endproperty
	a_pos: assert property (p_pos)
		else $error("positive reference wrong");
	property p_neg;
		ref_wr && reg_wdata[2:0] < 3'h5 ##1 ce |=>
		negative_reference_sel == 5'h01 << $past(reg_wdata[2:0], 2);
	endproperty
	a_neg: assert property (p_neg)
		else $error("negative reference wrong");
	property p_ref_top;
		ce && reg_rd && reg_addr == REF_SELECT_ADDR |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_ref_top: assert property (p_ref_top)
		else $error("reference top bits not zero");
endmodule
bind excitation_and_reference_select_regs exc_ref_checker i_exc_ref_checker (
	.clock, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.first_source_pin_sel, .second_source_pin_sel, .first_source_level_sel,
	.second_source_current_ua, .positive_reference_sel,
	.negative_reference_sel);

// File: sim/tb_excitation_and_reference_select_regs.sv
`timescale 1ns/1ps
module tb_excitation_and_reference_select_regs
	import exc_ref_pkg::*;
;
	logic clock = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, reg_rdata;
	logic [10:0] p1, p2, l1, l2;
	logic [11:0] c1, c2;
	logic [4:0] rp, rn;
	int err_total = 0, checks_done = 0, cycles = 0;
	int ua [0:10] = '{0, 50, 100, 250, 500, 750, 1000, 1500, 2000, 2500, 3000};
	always #2 clock = ~clock;
	excitation_and_reference_select_regs i_excitation_and_reference_select_regs (
		.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .first_source_pin_sel(p1),
		.second_source_pin_sel(p2), .first_source_level_sel(l1),
		.second_source_level_sel(l2), .first_source_current_ua(c1),
		.second_source_current_ua(c2), .positive_reference_sel(rp),
		.negative_reference_sel(rn));
	task automatic summarize;
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// cut a hang short well past the expected run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			summarize;
		end
	end
	task automatic chk(input string n, input logic [11:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [10:0] hot(input int c, lim);
		return c < lim ? 11'h001 << c : 11'h000;
	endfunction
	function automatic logic [11:0] cur(input int c);
		return c < 11 ? 12'(ua[c]) : 12'h000;
	endfunction
	// returns once the decoded outputs have caught up
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'h0;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1;
		rdata = reg_rdata;
	endtask
	task automatic t_reset;
		chk("pos ref", rp, 5'h01);
		chk("neg ref", rn, 5'h01);
		chk("pin1", p1, 11'h000);
		chk("cur1", c1, 12'h000);
		rd(PIN_SELECT_ADDR);
		chk("pin reg", rdata, 8'hbb);
		rd(LEVEL_ADDR);
		chk("level reg", rdata, 8'h00);
		rd(REF_SELECT_ADDR);
		chk("ref reg", rdata, 8'h00);
	endtask
	// both nibbles see every code, reserved ones included
	task automatic t_pins;
		for (int c = 0; c < 16; c++)
		begin
			wr(PIN_SELECT_ADDR, {c[3:0], 4'hf - c[3:0]});
			chk("pin2", p2, hot(c, 11));
			chk("pin1", p1, hot(15 - c, 11));
			rd(PIN_SELECT_ADDR);
			chk("pin back", rdata, {c[3:0], 4'hf - c[3:0]});
		end
	endtask
	task automatic t_levels;
		for (int c = 0; c < 16; c++)
		begin
			wr(LEVEL_ADDR, {c[3:0], 4'hf - c[3:0]});
			chk("lvl2", l2, hot(c, 11));
			chk("cur2", c2, cur(c));
			chk("lvl1", l1, hot(15 - c, 11));
			chk("cur1", c1, cur(15 - c));
		end
	endtask
	task automatic t_refs;
		for (int c = 0; c < 8; c++)
		begin
			wr(REF_SELECT_ADDR, {2'h3, c[2:0], 3'h7 - c[2:0]});
			chk("pos", rp, hot(c, 5));
			chk("neg", rn, hot(7 - c, 5));
			rd(REF_SELECT_ADDR);
			chk("ref back", rdata, {2'h0, c[2:0], 3'h7 - c[2:0]});
		end
		wr(8'h30, 8'h5a);
		rd(8'h30);
		chk("unmapped", rdata, 8'h00);
	endtask
	// a strobe while the enable is low is lost and read data hold
	task automatic t_freeze;
		wr(PIN_SELECT_ADDR, 8'hf0);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= PIN_SELECT_ADDR;
		@(posedge clock);
		reg_rd <= 1'h0;
		reg_wr <= 1'h1;
		reg_wdata <= 8'h12;
		ce <= 1'h0;
		@(posedge clock);
		reg_wr <= 1'h0;
		#1;
		chk("held rdata", reg_rdata, 8'hf0);
		@(posedge clock);
		ce <= 1'h1;
		#1;
		chk("pin1 held", p1, 11'h001);
		rd(PIN_SELECT_ADDR);
		chk("pin kept", rdata, 8'hf0);
	endtask
	// status flags reserved codes and which sources drive
	task automatic t_status;
		wr(PIN_SELECT_ADDR, 8'hc3);
		wr(LEVEL_ADDR, 8'hb2);
		wr(REF_SELECT_ADDR, 8'h29);
		rd(STATUS_ADDR);
		chk("status a", rdata, 8'h5a);
		@(posedge clock);
		#1;
		chk("rdata idle", reg_rdata, 8'h00);
		wr(PIN_SELECT_ADDR, 8'had);
		wr(LEVEL_ADDR, 8'h0f);
		wr(REF_SELECT_ADDR, 8'h3c);
		wr(STATUS_ADDR, 8'hff);
		rd(STATUS_ADDR);
		chk("status b", rdata, 8'h15);
	endtask
	// a second reset in mid-run restores every register
	task automatic t_rerun;
		wr(LEVEL_ADDR, 8'h55);
		wr(PIN_SELECT_ADDR, 8'h34);
		@(posedge clock);
		rstn <= 1'h0;
		@(posedge clock);
		#1;
		chk("cur1 in reset", c1, 12'h000);
		chk("pin1 in reset", p1, 11'h000);
		@(posedge clock);
		rstn <= 1'h1;
		@(posedge clock);
		#1;
		chk("pos ref again", rp, 5'h01);
		chk("neg ref again", rn, 5'h01);
		chk("cur2 again", c2, 12'h000);
		rd(PIN_SELECT_ADDR);
		chk("pin reg again", rdata, 8'hbb);
		rd(LEVEL_ADDR);
		chk("level reg again", rdata, 8'h00);
	endtask
	initial
	begin
		repeat (6) @(posedge clock);
		rstn <= 1'h1;
		@(posedge clock);
		#1;
		t_reset;
		t_pins;
		t_levels;
		t_refs;
		t_freeze;
		t_status;
		t_rerun;
		summarize;
	end
endmodule
